// ===== core/dctc_consts.svh
`ifndef DCTC_CONSTS_SVH
`define DCTC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define DCTC_IDX_SHORT_CTRL   5'h00
`define DCTC_IDX_COMMON_CTRL  5'h01
`define DCTC_IDX_LONG_CTRL    5'h02
`define DCTC_IDX_SYNC_CTRL    5'h03
`define DCTC_IDX_SHORT_RLD    5'h04
`define DCTC_IDX_LONG_RLD_LO  5'h06
`define DCTC_IDX_LONG_RLD_HI  5'h07
`define DCTC_IDX_CAP_LO       5'h08
`define DCTC_IDX_CAP_HI       5'h09
`define DCTC_IDX_IRQ_STAT     5'h10
`define DCTC_IDX_IRQ_CLR      5'h11
`define DCTC_IDX_IRQ_EN       5'h12

// ----------------------------------------------------------------
// Short and long counter control fields
// ----------------------------------------------------------------
`define DCTC_B_ENABLE    7
`define DCTC_B_TIMEOUT   5
`define DCTC_B_CLK_HI    4
`define DCTC_B_CLK_LO    3
`define DCTC_B_SINGLE    2
`define DCTC_B_TO_MASK   1
`define DCTC_B_PIN_SEL   0

// ----------------------------------------------------------------
// Common control fields
// ----------------------------------------------------------------
`define DCTC_B_PINGPONG  7
`define DCTC_B_THIRD_EN  6
`define DCTC_B_FUNC_HI   5
`define DCTC_B_FUNC_LO   4
`define DCTC_B_EDGE_MODE 3
`define DCTC_B_DEMOD     2
`define DCTC_B_CAP_FLAG  1
`define DCTC_B_CAP_MASK  0

// ----------------------------------------------------------------
// Sync control and interrupt fields
// ----------------------------------------------------------------
`define DCTC_B_LONG_RUN  7
`define DCTC_B_SHORT_RUN 6
`define DCTC_B_SYNC_MODE 5
`define DCTC_B_IRQ_SHORT 0
`define DCTC_B_IRQ_LONG  1
`define DCTC_B_IRQ_CAP   2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DCTC_RST_CTRL    8'h00
`define DCTC_RST_RLD     8'h00
`define DCTC_PRE_W       3

`endif

// ===== core/dctc_pkg.sv
package dctc_pkg;

    // Captured AHB address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [4:0] idx;
    } dctc_dphase_t;

    // Timer pin outputs
    typedef struct packed {
        logic third;
        logic second;
        logic first;
    } dctc_pins_t;

    // Logic combination on the third pin
    typedef enum logic [1:0] {
        DCTC_FN_AND  = 2'h0,
        DCTC_FN_OR   = 2'h1,
        DCTC_FN_NOR  = 2'h2,
        DCTC_FN_NAND = 2'h3
    } dctc_func_t;

endpackage : dctc_pkg

// ===== core/dctc_top.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "dctc_consts.svh"
module dctc_top #(
    parameter int SHORT_W = 8,
    parameter int LONG_W  = 16
) (
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic                demod_in,
    input  wire logic [2:0]          port_out,
    output dctc_pkg::dctc_pins_t     timer_pins,
    output logic                     short_irq,
    output logic                     long_irq,
    output logic                     irq
);

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    dctc_pkg::dctc_dphase_t dp;
    logic                   rd_ready;
    logic [7:0]             rd_mux;

    // Address phase accepted when selected, busy-free and ready
    wire       addr_take = hsel & htrans[1] & hready;
    wire       rd_wait   = dp.valid & ~dp.write & ~rd_ready;
    wire       wr_stb    = dp.valid & dp.write;
    wire [7:0] wd        = hwdata[7:0];

    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;

    // Write strobes per register
    wire wr_short  = wr_stb & (dp.idx == `DCTC_IDX_SHORT_CTRL);
    wire wr_common = wr_stb & (dp.idx == `DCTC_IDX_COMMON_CTRL);
    wire wr_long   = wr_stb & (dp.idx == `DCTC_IDX_LONG_CTRL);
    wire wr_sync   = wr_stb & (dp.idx == `DCTC_IDX_SYNC_CTRL);
    wire wr_srld   = wr_stb & (dp.idx == `DCTC_IDX_SHORT_RLD);
    wire wr_lrld_l = wr_stb & (dp.idx == `DCTC_IDX_LONG_RLD_LO);
    wire wr_lrld_h = wr_stb & (dp.idx == `DCTC_IDX_LONG_RLD_HI);
    wire wr_iclr   = wr_stb & (dp.idx == `DCTC_IDX_IRQ_CLR);
    wire wr_ien    = wr_stb & (dp.idx == `DCTC_IDX_IRQ_EN);

    // Address phase capture; held while a read waits
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dp <= '0;
        end else if (hreadyout) begin
            dp.valid <= addr_take;
            dp.write <= hwrite;
            dp.idx   <= haddr[6:2];
        end
    end

    // One wait state on reads, data from a flip-flop
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_ready <= 1'b0;
            hrdata   <= 32'h0000_0000;
        end else begin
            rd_ready <= rd_wait;
            if (rd_wait) begin
                hrdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [4:0]        short_cfg;
    logic [4:0]        long_cfg;
    logic [7:0]        common_cfg;
    logic              sync_mode;
    logic [1:0]        en;
    logic              short_to;
    logic              long_to;
    logic              cap_flag;
    logic [7:0]        short_rld;
    logic [15:0]       long_rld;
    logic [15:0]       capture;
    logic [2:0]        irq_stat;
    logic [2:0]        irq_en;

    wire       pingpong  = common_cfg[`DCTC_B_PINGPONG];
    wire       demod     = common_cfg[`DCTC_B_DEMOD];
    wire       edge_mode = common_cfg[`DCTC_B_EDGE_MODE];
    wire [1:0] single    = {long_cfg[`DCTC_B_SINGLE],
                            short_cfg[`DCTC_B_SINGLE]};

    // Settings written by software
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            short_cfg  <= 5'(`DCTC_RST_CTRL);
            long_cfg   <= 5'(`DCTC_RST_CTRL);
            common_cfg <= `DCTC_RST_CTRL;
            sync_mode  <= 1'b0;
            short_rld  <= `DCTC_RST_RLD;
            long_rld   <= {`DCTC_RST_RLD, `DCTC_RST_RLD};
            irq_en     <= 3'h0;
        end else begin
            if (wr_short)  short_cfg  <= wd[4:0];
            if (wr_long)   long_cfg   <= wd[4:0];
            if (wr_common) common_cfg <= wd;
            if (wr_sync)   sync_mode  <= wd[`DCTC_B_SYNC_MODE];
            if (wr_srld)   short_rld  <= wd;
            if (wr_lrld_l) long_rld[7:0]  <= wd;
            if (wr_lrld_h) long_rld[15:8] <= wd;
            if (wr_ien)    irq_en     <= wd[2:0];
        end
    end

    // ------------------------------------------------------------
    // Count ticks
    // ------------------------------------------------------------
    logic [`DCTC_PRE_W-1:0] pre;
    logic [1:0]             tick;
    logic [1:0]             tc;
    logic [1:0]             next_en;
    logic [1:0]             start;
    logic [LONG_W-1:0]      cnt [2];
    logic [LONG_W-1:0]      rld [2];
    logic [1:0]             tout;
    logic                   cap_evt;

    wire [1:0] clk_sel [2];
    assign clk_sel[0] = short_cfg[`DCTC_B_CLK_HI:`DCTC_B_CLK_LO];
    assign clk_sel[1] = long_cfg[`DCTC_B_CLK_HI:`DCTC_B_CLK_LO];
    assign rld[0]     = LONG_W'(short_rld[SHORT_W-1:0]);
    assign rld[1]     = long_rld[LONG_W-1:0];

    // Free-running prescaler, cleared for an aligned start
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pre <= '0;
        end else if (sync_mode & (|start)) begin
            pre <= '0;
        end else begin
            pre <= pre + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Enables: software, single-pass stop, ping-pong, sync
    // ------------------------------------------------------------
    logic [1:0] req_en;

    always_comb begin
        req_en = en;
        if (pingpong) begin
            if (tc[0]) begin
                req_en = 2'b10;
            end else if (tc[1]) begin
                req_en = 2'b01;
            end
        end else begin
            req_en = en & ~(tc & single);
        end
        if (wr_short) req_en[0] = wd[`DCTC_B_ENABLE];
        if (wr_long)  req_en[1] = wd[`DCTC_B_ENABLE];
        if (wr_sync) begin
            req_en = {wd[`DCTC_B_LONG_RUN],
                      wd[`DCTC_B_SHORT_RUN]};
        end
    end

    // Sync mode: either start brings both up together
    assign next_en = req_en |
                     {2{sync_mode & (|(req_en & ~en))}};
    assign start   = next_en & ~en;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en <= 2'b00;
        end else begin
            en <= next_en;
        end
    end

    // ------------------------------------------------------------
    // Per-counter datapath
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_cnt
        // Tick when the selected low prescaler bits are all ones;
        // outside sync mode enable is not phase aligned so the first tick may be short
        wire [`DCTC_PRE_W-1:0] sel_mask =
            `DCTC_PRE_W'((4'h1 << clk_sel[c]) - 4'h1);
        assign tick[c] = ((pre & sel_mask) == sel_mask);
        assign tc[c]   = en[c] & tick[c] & (cnt[c] == '0);

        wire load = start[c] | (tc[c] & ~single[c]) |
                    ((c == 1) & cap_evt);

        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                cnt[c]  <= '0;
                tout[c] <= 1'b0;
            end else begin
                if (load) begin
                    cnt[c] <= rld[c];
                end else if (en[c] & tick[c]) begin
                    cnt[c] <= cnt[c] - 1'b1;
                end
                if (tc[c]) begin
                    tout[c] <= ~tout[c];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Demodulation capture on the long counter
    // ------------------------------------------------------------
    logic demod_prev;
    logic first_seen;

    wire in_edge = demod_in ^ demod_prev;
    assign cap_evt = demod & en[1] & in_edge &
                     (~edge_mode | ~first_seen);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            demod_prev <= 1'b0;
            first_seen <= 1'b0;
            capture    <= 16'h0000;
        end else begin
            demod_prev <= demod_in;
            if (start[1] | ~demod) begin
                first_seen <= 1'b0;
            end else if (cap_evt) begin
                first_seen <= 1'b1;
            end
            if (cap_evt) begin
                capture <= 16'(cnt[1]);
            end
        end
    end

    // ------------------------------------------------------------
    // Clear-on-one flags; a set in the clearing cycle wins
    // ------------------------------------------------------------
    wire clr_sto = wr_short  & wd[`DCTC_B_TIMEOUT];
    wire clr_lto = wr_long   & wd[`DCTC_B_TIMEOUT];
    wire clr_cap = wr_common & wd[`DCTC_B_CAP_FLAG];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            short_to <= 1'b0;
            long_to  <= 1'b0;
            cap_flag <= 1'b0;
        end else begin
            short_to <= (short_to & ~clr_sto) | tc[0];
            long_to  <= (long_to & ~clr_lto) | tc[1];
            cap_flag <= (cap_flag & ~clr_cap) | cap_evt;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [2:0] irq_evt = {cap_evt, tc[1], tc[0]};
    wire [2:0] irq_clr = wr_iclr ? wd[2:0] : 3'h0;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
        end
    end

    // Two source lines plus the combined level
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            short_irq <= 1'b0;
            long_irq  <= 1'b0;
            irq       <= 1'b0;
        end else begin
            short_irq <= short_to & short_cfg[`DCTC_B_TO_MASK];
            long_irq  <= (long_to & long_cfg[`DCTC_B_TO_MASK]) |
                         (cap_flag & common_cfg[`DCTC_B_CAP_MASK]);
            irq       <= |(irq_stat & irq_en);
        end
    end

    // ------------------------------------------------------------
    // Timer pin routing
    // ------------------------------------------------------------
    dctc_pkg::dctc_func_t func;
    logic                 comb_out;

    assign func = dctc_pkg::dctc_func_t'(
                  common_cfg[`DCTC_B_FUNC_HI:`DCTC_B_FUNC_LO]);

    // Combination of both counter outputs
    always_comb begin
        case (func)
            dctc_pkg::DCTC_FN_AND:  comb_out = tout[0] & tout[1];
            dctc_pkg::DCTC_FN_OR:   comb_out = tout[0] | tout[1];
            dctc_pkg::DCTC_FN_NOR:  comb_out = ~(tout[0] | tout[1]);
            dctc_pkg::DCTC_FN_NAND: comb_out = ~(tout[0] & tout[1]);
            default:                comb_out = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            timer_pins <= '0;
        end else begin
            timer_pins.first  <= short_cfg[`DCTC_B_PIN_SEL] ?
                                 tout[0] : port_out[0];
            timer_pins.second <= long_cfg[`DCTC_B_PIN_SEL] ?
                                 tout[1] : port_out[1];
            timer_pins.third  <= common_cfg[`DCTC_B_THIRD_EN] ?
                                 comb_out : port_out[2];
        end
    end

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    wire [7:0] rd_short  = {en[0], 1'b0, short_to, short_cfg};
    wire [7:0] rd_long   = {en[1], 1'b0, long_to, long_cfg};
    wire [7:0] rd_common = {common_cfg[7:2], cap_flag, common_cfg[0]};
    wire [7:0] rd_sync   = {en[1], en[0], sync_mode, 5'h00};

    assign rd_mux =
        (dp.idx == `DCTC_IDX_SHORT_CTRL)  ? rd_short  :
        (dp.idx == `DCTC_IDX_COMMON_CTRL) ? rd_common :
        (dp.idx == `DCTC_IDX_LONG_CTRL)   ? rd_long   :
        (dp.idx == `DCTC_IDX_SYNC_CTRL)   ? rd_sync   :
        (dp.idx == `DCTC_IDX_SHORT_RLD)   ? short_rld :
        (dp.idx == `DCTC_IDX_LONG_RLD_LO) ? long_rld[7:0]  :
        (dp.idx == `DCTC_IDX_LONG_RLD_HI) ? long_rld[15:8] :
        (dp.idx == `DCTC_IDX_CAP_LO)      ? capture[7:0]   :
        (dp.idx == `DCTC_IDX_CAP_HI)      ? capture[15:8]  :
        (dp.idx == `DCTC_IDX_IRQ_STAT)    ? {5'h00, irq_stat} :
        (dp.idx == `DCTC_IDX_IRQ_EN)      ? {5'h00, irq_en}   :
                                            8'h00;

endmodule : dctc_top

// ===== dv/dctc_properties.sv
`timescale 1ns/100ps
module dctc_properties (
    input wire logic                 core_clk,
    input wire logic                 sys_rst,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [31:0]          hwdata,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic [31:0]          hrdata,
    input wire logic [2:0]           port_out,
    input wire dctc_pkg::dctc_pins_t timer_pins,
    input wire logic                 short_irq,
    input wire logic                 long_irq,
    input wire logic                 irq
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    // Transfer decode and write data phase tracking
    logic       wr_v;
    logic [4:0] wr_idx;
    logic       sel_first;
    wire        taken    = hsel && htrans[1] && hready;
    wire        wr_short = wr_v && (wr_idx == 5'h00);
    wire        wr_long  = wr_v && (wr_idx == 5'h01 || wr_idx == 5'h02);
    wire        wr_irq   = wr_v && (wr_idx == 5'h11 || wr_idx == 5'h12);

    // Copy of the first pin select bit
    always_ff @(posedge core_clk) begin
        wr_v   <= !sys_rst && taken && hwrite;
        wr_idx <= haddr[6:2];
        if (sys_rst) begin
            sel_first <= 1'b0;
        end else if (wr_short) begin
            sel_first <= hwdata[0];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_rd_taken;
        taken && !hwrite;
    endsequence
    sequence s_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_read_wait: assert property (s_rd_taken |=> s_rd_answer)
        else $error("read answer not after one wait");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_rdata_hold: assert property
        (!$stable(hrdata) |-> !hreadyout || !$past(hreadyout))
        else $error("read data changed outside a read");
    a_unmapped_zero: assert property
        ((s_rd_taken ##0 (haddr[6:2] == 5'h05))
        |=> (s_rd_answer ##0 (hrdata == 32'h00000000)))
        else $error("unmapped read not zero");
    a_first_port: assert property (!$past(sel_first) && !$past(sys_rst)
        |-> timer_pins.first == $past(port_out[0]))
        else $error("first pin not port data");
    a_short_clear: assert property ($fell(short_irq)
        |-> $past(wr_short) || $past(wr_short, 2))
        else $error("short interrupt fell without write");
    a_long_clear: assert property ($fell(long_irq)
        |-> $past(wr_long) || $past(wr_long, 2))
        else $error("long interrupt fell without write");
    a_irq_clear: assert property ($fell(irq)
        |-> $past(wr_irq) || $past(wr_irq, 2))
        else $error("interrupt fell without write");
endmodule : dctc_properties

bind dctc_top dctc_properties i_dctc_properties (
    .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .port_out, .timer_pins,
    .short_irq, .long_irq, .irq
);

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 core_clk;
    logic                 sys_rst;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [31:0]          hwdata;
    logic                 demod_in;
    logic [2:0]           port_out;
    logic                 hreadyout;
    logic                 hresp;
    logic [31:0]          hrdata;
    dctc_pkg::dctc_pins_t timer_pins;
    logic                 short_irq;
    logic                 long_irq;
    logic                 irq;
    logic [31:0]          rd_val;
    int                   errors;
    int                   n_tests;
    int                   cycles;

    dctc_top i_dctc_top (
        .core_clk, .sys_rst, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .demod_in, .port_out, .timer_pins, .short_irq,
        .long_irq, .irq
    );

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            results();
        end
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic wait_rdy();
        @(posedge core_clk);
        while (hreadyout !== 1'b1)
            @(posedge core_clk);
        rd_val = hrdata;
    endtask : wait_rdy

    task automatic bus(input logic [4:0] idx, input logic wr,
                       input logic [7:0] d);
        @(posedge core_clk);
        haddr  <= {25'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask : bus

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask : wr

    task automatic rc(input logic [4:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 8'h00);
        chk(rd_val, exp);
    endtask : rc

    // Lets registered pins and interrupts follow a write
    task automatic settle();
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rc(5'h03, 32'h0); // sync idle
        rc(5'h00, 32'h0); // pin select clear
        wr(5'h05, 8'hff);
        rc(5'h05, 32'h0);
    endtask : t_reset

    task automatic t_pins();
        port_out <= 3'h7;
        settle();
        chk({29'h0, timer_pins}, 32'h7); // port data
        wr(5'h00, 8'h20); // clear flags first
        wr(5'h02, 8'h20);
        wr(5'h04, 8'h02);
        wr(5'h06, 8'h02);
        wr(5'h07, 8'h00);
        wr(5'h00, 8'h05);
        wr(5'h02, 8'h05);
        settle();
        chk({29'h0, timer_pins}, 32'h4); // outputs low
        wr(5'h00, 8'h85); // start
        wr(5'h02, 8'h85);
        repeat (8) @(posedge core_clk);
        rc(5'h00, 32'h25); // stopped, flag
        rc(5'h02, 32'h25); // stopped, flag
        settle();
        chk({29'h0, timer_pins}, 32'h7); // toggled
        for (int f = 0; f < 4; f++) begin
            wr(5'h01, {2'h1, f[1:0], 4'h0});
            settle();
            chk({29'h0, timer_pins}, f < 2 ? 32'h7 : 32'h3);
        end
        wr(5'h00, 8'h05);
        rc(5'h00, 32'h25); // zero write keeps flag
        wr(5'h00, 8'h20);
        rc(5'h00, 32'h00); // one clears flag
        wr(5'h01, 8'h00);
        port_out <= 3'h0;
        settle();
        chk({29'h0, timer_pins}, 32'h2); // first back to port
    endtask : t_pins

    task automatic t_irq();
        rc(5'h10, 32'h3); // both tc seen
        wr(5'h12, 8'h01);
        settle();
        chk({29'h0, short_irq, long_irq, irq}, 32'h1);
        wr(5'h02, 8'h07); // flag bit written as 0
        settle();
        chk({29'h0, short_irq, long_irq, irq}, 32'h3); // mask
        wr(5'h02, 8'h27);
        settle();
        chk({29'h0, short_irq, long_irq, irq}, 32'h1);
        wr(5'h12, 8'h00);
        settle();
        chk({29'h0, short_irq, long_irq, irq}, 32'h0); // masked
        wr(5'h11, 8'h07);
        rc(5'h10, 32'h0); // cleared
    endtask : t_irq

    task automatic t_pingpong();
        wr(5'h04, 8'h30);
        wr(5'h06, 8'h30);
        wr(5'h02, 8'h20);
        wr(5'h01, 8'h80);
        wr(5'h00, 8'ha0);
        repeat (60) @(posedge core_clk);
        rc(5'h03, 32'h80); // long took over
        rc(5'h00, 32'h20); // short flag
        repeat (40) @(posedge core_clk);
        rc(5'h03, 32'h40); // short again
        rc(5'h02, 32'h20); // long flag
        wr(5'h01, 8'h00);
        wr(5'h03, 8'h00);
        rc(5'h03, 32'h0); // stop both
    endtask : t_pingpong

    task automatic t_sync();
        wr(5'h03, 8'h20);
        wr(5'h00, 8'h80);
        rc(5'h03, 32'he0); // both started
        wr(5'h03, 8'h20);
        rc(5'h03, 32'h20);
        wr(5'h03, 8'hc0);
        rc(5'h03, 32'hc0);
        wr(5'h03, 8'h20);
        wr(5'h00, 8'h20); // clear flag first
        wr(5'h04, 8'h01);
        wr(5'h00, 8'h9e); // slowest tick, aligned start
        rc(5'h00, 32'h9e); // still running
        repeat (16) @(posedge core_clk);
        rc(5'h00, 32'h3e); // stopped on slow tick
        chk({31'h0, short_irq}, 32'h1); // masked timeout
        wr(5'h00, 8'h20);
        wr(5'h03, 8'h00);
    endtask : t_sync

    task automatic t_demod();
        logic [31:0] cap;
        wr(5'h06, 8'hff);
        wr(5'h01, 8'h0d);
        wr(5'h02, 8'h80);
        demod_in <= 1'b1;
        repeat (20) @(posedge core_clk);
        bus(5'h08, 1'b0, 8'h00);
        cap = rd_val;
        chk(cap, 32'h000000ff); // first edge takes fresh count
        demod_in <= 1'b0;
        repeat (20) @(posedge core_clk);
        rc(5'h08, cap); // later edge ignored
        rc(5'h01, 32'h0f); // capture flag
        settle();
        chk({29'h0, short_irq, long_irq, irq}, 32'h2);
        wr(5'h01, 8'h0f);
        rc(5'h01, 32'h0d); // flag cleared
    endtask : t_demod

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic results();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    initial begin
        sys_rst  = 1'b1;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hwdata   = 32'h0;
        demod_in = 1'b0;
        port_out = 3'h0;
        errors   = 0;
        n_tests  = 0;
        cycles   = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_pins();
        t_irq();
        t_pingpong();
        t_sync();
        t_demod();
        results();
    end
endmodule : tb
